// [hdl/rcr_defines.svh]
// Constants of the RAM control and refresh block.
// Assumes a 100 MHz processor clock; included by package and control module.
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH
`define RCR_CLK_PERIOD_NS 10
`define RCR_RAS_OFF_NS 100
// More than the off time: one whole cycle beyond the quotient
`define RCR_RAS_OFF_CYC ((`RCR_RAS_OFF_NS / `RCR_CLK_PERIOD_NS) + 1)
`define RCR_DATA_CYC 4'h3
`define RCR_PRECH_CYC 4'h2
`define RCR_CBR_CYC 4'h2
`define RCR_ILD_NONE 2'h0
`define RCR_ILD_ONE 2'h1
`define RCR_ILD_TWO 2'h2
`define RCR_ILD_THREE 2'h3
`define RCR_OFFSET_RST 4'h0
`define RCR_FLAG_RST 1'b0
`endif

// [hdl/rcr_pkg.sv]
// Types of the RAM control and refresh block.
// Assumes the constants header sits beside it.
`include "rcr_defines.svh"
package rcr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_P_ROW = 4'h1, ST_P_COL = 4'h3, ST_PRECH = 4'h2,
    ST_CBR_CAS = 4'h6, ST_CBR_RAS = 4'h7, ST_T_ROW = 4'h5,
    ST_T_COL = 4'h4, ST_T_RASOFF = 4'hC, ST_T_RASON = 4'hD,
    ST_T_LOAD = 4'hF, ST_T_END = 4'hE
  } rcr_state_t;
  typedef enum logic [2:0] {
    SEL_P_ROW = 3'h0, SEL_P_COL = 3'h1, SEL_T_ROW = 3'h2,
    SEL_T_COL = 3'h3, SEL_L_ROW = 3'h4
  } rcr_sel_t;
  typedef struct packed {
    rcr_state_t st;
    logic [3:0] cnt;
    logic flag;
    logic flag_out_n;
    logic [3:0] offset;
    logic [7:0] row_ld;
    rcr_sel_t sel;
    logic casen_v;
    logic casen_d;
    logic ras_d_n;
    logic ras_v_n;
    logic cas_d_n;
    logic cas_v_n;
    logic vwe_n;
    logic voe_n;
    logic doe_n;
    logic dwe_n;
    logic rfsh_all_n;
    logic hold;
    logic [7:0] addr;
    logic addr8;
    logic vbank;
  } rcr_state_s_t;
endpackage

// [hdl/rcr_addr_mux.sv]
// One four-line slice of the row/column address multiplexer.
// Assumes the select code is settled with the strobes it serves.
`timescale 1ns/1ps
module rcr_addr_mux #(
  parameter int W = 4
) (
  input wire rcr_pkg::rcr_sel_t sel,
  input wire logic [W-1:0] p_row,
  input wire logic [W-1:0] p_col,
  input wire logic [W-1:0] t_row,
  input wire logic [W-1:0] t_col,
  input wire logic [W-1:0] l_row,
  output logic [W-1:0] out
);
  import rcr_pkg::*;
  always_comb begin
    case (sel)
      SEL_P_ROW: out = p_row;
      SEL_P_COL: out = p_col;
      SEL_T_ROW: out = t_row;
      SEL_T_COL: out = t_col;
      SEL_L_ROW: out = l_row;
      default: out = '0;
    endcase
  end
endmodule

// [hdl/rcr_ram_control.sv]
// RAM sequencer, strobe generation, refresh and timing-table offset.
// Assumes processor strobes and selects are synchronous to SYS_CLK and
// held until the cycle ends; HOLDA stays high through a table cycle.
`timescale 1ns/1ps
`include "rcr_defines.svh"
// Summary of operation
// - Serve processor cycles and hold-acknowledged timing-table cycles.
// - Processor reads and writes base DRAM, optional DRAM and VRAM.
// - Table cycle: plain DRAM entry read or VRAM load one to three.
// - Three-bit select code steers the address multiplexers.
// - Separate VRAM and DRAM column-strobe enables.
// - Independent row strobes for DRAM and VRAM.
// - Column strobes plus active-low VRAM write and output enables.
// - Active-low DRAM output and write enables.
// - Ninth address line carries bit 17 on row, 18 on column.
// - Four-bit counter gives the table entry offset.
// - Eight address lines from two four-line multiplexer slices.
// - Refresh flag set or cleared by one I/O write, then held.
// - Flag set blocks hold request, so no table cycles.
// - Refresh-all is the flag gated by the processor read.
// - Refresh-all on a non-memory cycle does CAS-before-RAS refresh.
// - Table cycle keeps CAS and OE, drops DRAM RAS over 100 ns.
// - Table cycles without a load also refresh VRAM CAS-before-RAS.
// - VRAM up to 2048 pixels, 4096 with the second bank.
// - Both selects together mean the optional DRAM.
// - Load code picks row: keep seven or six bits, fill low bits.
module rcr_ram_control (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [18:0] CPU_ADDR,
  input wire logic CPU_RD,
  input wire logic CPU_WR,
  input wire logic DRAM_SELECT,
  input wire logic VRAM_SELECT,
  input wire logic VRAM_4K_MODE,
  input wire logic FLAG_WR,
  input wire logic FLAG_DATA,
  input wire logic HOLD_REQ_IN,
  input wire logic HOLDA,
  input wire logic [15:0] TABLE_BASE,
  input wire logic INTERLOAD_CODE_BIT0,
  input wire logic INTERLOAD_CODE_BIT1,
  input wire logic ROW_LOAD_WR,
  input wire logic [7:0] ROW_LOAD_ADDR,
  input wire logic INTLD_DONE,
  output logic [2:0] ADDR_SELECT,
  output logic VRAM_COLSTROBE_ENABLE,
  output logic DRAM_COLSTROBE_ENABLE,
  output logic DRAM_ROWSTROBE_N,
  output logic VRAM_ROWSTROBE_N,
  output logic DRAM_COLSTROBE_N,
  output logic VRAM_COLSTROBE_N,
  output logic VRAM_WRITE_ENABLE_N,
  output logic VRAM_OUTPUT_ENABLE_N,
  output logic DRAM_OUTPUT_ENABLE_N,
  output logic DRAM_WRITE_ENABLE_N,
  output logic REFRESH_MODE_FLAG_N,
  output logic REFRESH_ALL_N,
  output logic HOLD,
  output logic [7:0] MEM_ADDR_LINES,
  output logic MEM_ADDR_NINTH_LINE,
  output logic VRAM_BANK,
  output logic [3:0] TABLE_OFFSET
);
  import rcr_pkg::*;

  rcr_state_s_t s_q;
  rcr_state_s_t s_d;
  logic [1:0] ild_code;
  logic mem_cyc;
  logic dram_cyc;
  logic [7:0] load_row;
  logic [7:0] mux_out;
  rcr_sel_t sel_nx;
  logic [3:0] ras_hi_cnt_q;

  // Row of an intermediate load from the last channel-1 row
  function automatic logic [7:0] ld_row(input logic [1:0] code,
                                        input logic [7:0] row);
    logic [7:0] r;
    r = row;
    case (code)
      `RCR_ILD_ONE: r = {row[7:1], 1'b1};
      `RCR_ILD_TWO: r = {row[7:2], 2'b10};
      `RCR_ILD_THREE: r = {row[7:2], 2'b11};
      default: r = row;
    endcase
    return r;
  endfunction

  // Release every memory strobe
  function automatic rcr_state_s_t idle_pins(input rcr_state_s_t s);
    rcr_state_s_t r;
    r = s;
    r.casen_v = 1'b0;
    r.casen_d = 1'b0;
    r.ras_d_n = 1'b1;
    r.ras_v_n = 1'b1;
    r.cas_d_n = 1'b1;
    r.cas_v_n = 1'b1;
    r.vwe_n = 1'b1;
    r.voe_n = 1'b1;
    r.doe_n = 1'b1;
    r.dwe_n = 1'b1;
    return r;
  endfunction

  assign ild_code = {INTERLOAD_CODE_BIT1, INTERLOAD_CODE_BIT0};
  assign mem_cyc = DRAM_SELECT | VRAM_SELECT;
  assign dram_cyc = DRAM_SELECT;
  assign load_row = ld_row(ild_code, s_q.row_ld);
  assign sel_nx = s_d.sel;

  rcr_addr_mux #(.W(4)) u_mux_lo (
    .sel(sel_nx),
    .p_row(CPU_ADDR[4:1]),
    .p_col(CPU_ADDR[12:9]),
    .t_row(s_d.offset),
    .t_col(TABLE_BASE[11:8]),
    .l_row(load_row[3:0]),
    .out(mux_out[3:0])
  );
  rcr_addr_mux #(.W(4)) u_mux_hi (
    .sel(sel_nx),
    .p_row(CPU_ADDR[8:5]),
    .p_col(CPU_ADDR[16:13]),
    .t_row(TABLE_BASE[7:4]),
    .t_col(TABLE_BASE[15:12]),
    .l_row(load_row[7:4]),
    .out(mux_out[7:4])
  );

  always_comb begin
    s_d = s_q;
    if (FLAG_WR) begin
      s_d.flag = FLAG_DATA;
    end
    if (ROW_LOAD_WR) begin
      s_d.row_ld = ROW_LOAD_ADDR;
    end
    s_d.hold = HOLD_REQ_IN & ~s_q.flag;
    s_d.rfsh_all_n = ~(s_q.flag & CPU_RD);
    s_d.cnt = s_q.cnt + 4'h1;
    case (s_q.st)
      ST_IDLE: begin
        s_d = idle_pins(s_d);
        s_d.cnt = 4'h0;
        if (HOLDA) begin
          s_d.st = ST_T_ROW;
          s_d.sel = SEL_T_ROW;
          s_d.ras_d_n = 1'b0;
          if (ild_code == `RCR_ILD_NONE) begin
            s_d.casen_v = 1'b1;
            s_d.cas_v_n = 1'b0;
          end
        end else if ((CPU_RD | CPU_WR) & mem_cyc) begin
          s_d.st = ST_P_ROW;
          s_d.sel = SEL_P_ROW;
          s_d.ras_d_n = ~dram_cyc;
          s_d.ras_v_n = dram_cyc;
          s_d.vbank = VRAM_4K_MODE & ~dram_cyc & CPU_ADDR[17];
        end else if (s_q.flag & CPU_RD) begin
          s_d.st = ST_CBR_CAS;
          s_d.casen_d = 1'b1;
          s_d.casen_v = 1'b1;
          s_d.cas_d_n = 1'b0;
          s_d.cas_v_n = 1'b0;
        end
      end
      ST_P_ROW: begin
        s_d.st = ST_P_COL;
        s_d.sel = SEL_P_COL;
        s_d.casen_d = dram_cyc;
        s_d.casen_v = ~dram_cyc;
        s_d.cas_d_n = ~dram_cyc;
        s_d.cas_v_n = dram_cyc;
        s_d.dwe_n = ~(dram_cyc & CPU_WR);
        s_d.doe_n = ~(dram_cyc & CPU_RD);
        s_d.vwe_n = ~(~dram_cyc & CPU_WR);
        s_d.voe_n = ~(~dram_cyc & CPU_RD);
      end
      ST_P_COL: begin
        if (!(CPU_RD | CPU_WR)) begin
          s_d = idle_pins(s_d);
          s_d.st = ST_PRECH;
          s_d.cnt = 4'h0;
        end
      end
      ST_CBR_CAS: begin
        if (s_q.cnt == `RCR_CBR_CYC) begin
          s_d.st = ST_CBR_RAS;
          s_d.ras_d_n = 1'b0;
          s_d.ras_v_n = 1'b0;
        end
      end
      ST_CBR_RAS: begin
        // One refresh per read: wait for the read to end
        if (!CPU_RD) begin
          s_d = idle_pins(s_d);
          s_d.st = ST_PRECH;
          s_d.cnt = 4'h0;
        end
      end
      ST_T_ROW: begin
        s_d.st = ST_T_COL;
        s_d.sel = SEL_T_COL;
        s_d.casen_d = 1'b1;
        s_d.cas_d_n = 1'b0;
        s_d.doe_n = 1'b0;
        s_d.cnt = 4'h0;
        if (ild_code == `RCR_ILD_NONE) begin
          s_d.ras_v_n = 1'b0;
        end
      end
      ST_T_COL: begin
        if (s_q.cnt == `RCR_DATA_CYC) begin
          s_d.st = ST_T_RASOFF;
          s_d.ras_d_n = 1'b1;
          s_d.cnt = 4'h1;
        end
      end
      ST_T_RASOFF: begin
        if (s_q.cnt == 4'(`RCR_RAS_OFF_CYC)) begin
          s_d.st = ST_T_RASON;
          s_d.ras_d_n = 1'b0;
          s_d.cnt = 4'h0;
        end
      end
      ST_T_RASON: begin
        if (s_q.cnt == `RCR_DATA_CYC) begin
          s_d = idle_pins(s_d);
          s_d.cnt = 4'h0;
          if (ild_code == `RCR_ILD_NONE) begin
            s_d.st = ST_T_END;
          end else begin
            s_d.st = ST_T_LOAD;
            s_d.sel = SEL_L_ROW;
            s_d.voe_n = 1'b0;
          end
        end
      end
      ST_T_LOAD: begin
        // Transfer needs OE low before RAS falls
        s_d.ras_v_n = 1'b0;
        if (INTLD_DONE & ~s_q.ras_v_n) begin
          s_d = idle_pins(s_d);
          s_d.st = ST_T_END;
        end
      end
      ST_T_END: begin
        s_d.offset = s_q.offset + 4'h1;
        s_d.st = ST_PRECH;
        s_d.cnt = 4'h0;
      end
      ST_PRECH: begin
        if (s_q.cnt == `RCR_PRECH_CYC) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d = idle_pins(s_d);
        s_d.st = ST_IDLE;
      end
    endcase
    // Registered copy so the flag pin comes straight from a flip-flop
    s_d.flag_out_n = ~s_d.flag;
    s_d.addr8 = (s_d.sel == SEL_P_ROW) ? CPU_ADDR[17] :
                (s_d.sel == SEL_P_COL) ? CPU_ADDR[18] : 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      s_q <= idle_pins('0);
      s_q.st <= ST_IDLE;
      s_q.sel <= SEL_P_ROW;
      s_q.flag <= `RCR_FLAG_RST;
      s_q.offset <= `RCR_OFFSET_RST;
      s_q.rfsh_all_n <= 1'b1;
      s_q.flag_out_n <= 1'b1;
    end else begin
      s_q <= s_d;
      // Mux output taken here; feeding it back into s_d would loop
      s_q.addr <= mux_out;
    end
  end

  assign ADDR_SELECT = s_q.sel;
  assign VRAM_COLSTROBE_ENABLE = s_q.casen_v;
  assign DRAM_COLSTROBE_ENABLE = s_q.casen_d;
  assign DRAM_ROWSTROBE_N = s_q.ras_d_n;
  assign VRAM_ROWSTROBE_N = s_q.ras_v_n;
  assign DRAM_COLSTROBE_N = s_q.cas_d_n;
  assign VRAM_COLSTROBE_N = s_q.cas_v_n;
  assign VRAM_WRITE_ENABLE_N = s_q.vwe_n;
  assign VRAM_OUTPUT_ENABLE_N = s_q.voe_n;
  assign DRAM_OUTPUT_ENABLE_N = s_q.doe_n;
  assign DRAM_WRITE_ENABLE_N = s_q.dwe_n;
  assign REFRESH_MODE_FLAG_N = s_q.flag_out_n;
  assign REFRESH_ALL_N = s_q.rfsh_all_n;
  assign HOLD = s_q.hold;
  assign MEM_ADDR_LINES = s_q.addr;
  assign MEM_ADDR_NINTH_LINE = s_q.addr8;
  assign VRAM_BANK = s_q.vbank;
  assign TABLE_OFFSET = s_q.offset;

  // Helper: DRAM RAS high cycles inside a table cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      ras_hi_cnt_q <= 4'h0;
    end else if (s_q.st == ST_T_RASOFF) begin
      ras_hi_cnt_q <= ras_hi_cnt_q + 4'h1;
    end else begin
      ras_hi_cnt_q <= 4'h0;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  hold_gate_a: assert property (
    s_q.flag && $past(s_q.flag) |-> !HOLD)
    else $error("hold raised while refresh flag set");
  rfsh_all_a: assert property (
    REFRESH_ALL_N == !($past(s_q.flag) && $past(CPU_RD)))
    else $error("refresh-all not flag gated by read");
  flag_keep_a: assert property (
    !$past(FLAG_WR) |-> $stable(REFRESH_MODE_FLAG_N))
    else $error("refresh flag changed without write");
  cbr_order_a: assert property (
    $fell(DRAM_ROWSTROBE_N) && s_q.st == ST_CBR_RAS
      |-> $past(!DRAM_COLSTROBE_N) && $past(!VRAM_COLSTROBE_N))
    else $error("refresh RAS fell before CAS");
  hidden_ras_a: assert property (
    s_q.st == ST_T_RASOFF && s_d.st == ST_T_RASON
      |-> ras_hi_cnt_q >= 4'(`RCR_RAS_OFF_CYC - 1)
          && !DRAM_COLSTROBE_N && !DRAM_OUTPUT_ENABLE_N)
    else $error("hidden refresh RAS off too short");
  vram_cbr_a: assert property (
    $past(s_q.st) == ST_T_ROW && s_q.st == ST_T_COL && !VRAM_ROWSTROBE_N
      |-> $past(!VRAM_COLSTROBE_N))
    else $error("VRAM refresh RAS without prior CAS");
  offset_step_a: assert property (
    s_q.st == ST_T_END |=> TABLE_OFFSET == $past(TABLE_OFFSET) + 4'h1)
    else $error("table offset did not advance");
  owner_excl_a: assert property (
    s_q.st == ST_P_ROW |-> $past(s_q.st) == ST_IDLE && !$past(HOLDA))
    else $error("processor cycle began under hold");
  ninth_line_a: assert property (
    s_q.st == ST_P_ROW ##1 s_q.st == ST_P_COL
      |-> MEM_ADDR_NINTH_LINE == $past(CPU_ADDR[18]))
    else $error("ninth line wrong in column phase");
  load_row_a: assert property (
    s_q.st == ST_T_LOAD && ild_code == `RCR_ILD_ONE
      |-> MEM_ADDR_LINES == {s_q.row_ld[7:1], 1'b1})
    else $error("intermediate load one row wrong");
  cas_en_a: assert property (
    DRAM_COLSTROBE_ENABLE == !DRAM_COLSTROBE_N
      && VRAM_COLSTROBE_ENABLE == !VRAM_COLSTROBE_N)
    else $error("column enable and strobe disagree");

  tt_plain_c: cover property (s_q.st == ST_T_COL ##[1:30] s_q.st == ST_T_END);
  tt_load_c: cover property (s_q.st == ST_T_LOAD ##[1:60] s_q.st == ST_T_END);
  cpu_wr_c: cover property (s_q.st == ST_P_COL && !DRAM_WRITE_ENABLE_N);
  cbr_c: cover property (s_q.st == ST_CBR_CAS ##[1:8] s_q.st == ST_CBR_RAS);
endmodule

// [testbench/rcr_mem_model.sv]
// Behavioural memory group: watches the row and column strobes.
// Assumes strobes change only just after the rising clock edge.
`timescale 1ns/1ps
module rcr_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dram_ras_n,
  input wire logic dram_cas_n,
  input wire logic vram_ras_n,
  input wire logic vram_cas_n,
  output logic [7:0] dram_cbr,
  output logic [7:0] vram_cbr,
  output logic [7:0] ras_off
);
  logic d_ras_q;
  logic v_ras_q;
  logic [7:0] run_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      d_ras_q <= 1'b1;
      v_ras_q <= 1'b1;
      run_q <= 8'h00;
      dram_cbr <= 8'h00;
      vram_cbr <= 8'h00;
      ras_off <= 8'h00;
    end else begin
      d_ras_q <= dram_ras_n;
      v_ras_q <= vram_ras_n;
      // A RAS fall with CAS already low is a refresh, hidden or plain
      if (d_ras_q && !dram_ras_n && !dram_cas_n) begin
        dram_cbr <= dram_cbr + 8'h01;
        ras_off <= run_q;
      end
      if (v_ras_q && !vram_ras_n && !vram_cas_n) begin
        vram_cbr <= vram_cbr + 8'h01;
      end
      // Counts only RAS-off time with data held; too short loses cells
      run_q <= (dram_ras_n && !dram_cas_n) ? run_q + 8'h01 : 8'h00;
    end
  end
endmodule

// [testbench/rcr_ram_control_tb.sv]
// Self-checking bench for the RAM control and refresh block.
// Assumes the memory model is compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module rcr_ram_control_tb;
  import rcr_pkg::*;
  logic SYS_CLK, RESETN, CPU_RD, CPU_WR, DRAM_SELECT, VRAM_SELECT;
  logic VRAM_4K_MODE, FLAG_WR, FLAG_DATA, HOLD_REQ_IN, HOLDA;
  logic INTERLOAD_CODE_BIT0, INTERLOAD_CODE_BIT1, ROW_LOAD_WR, INTLD_DONE;
  logic [18:0] CPU_ADDR;
  logic [15:0] TABLE_BASE;
  logic [7:0] ROW_LOAD_ADDR, MEM_ADDR_LINES, dram_cbr, vram_cbr, ras_off;
  logic [2:0] ADDR_SELECT;
  logic VRAM_COLSTROBE_ENABLE, DRAM_COLSTROBE_ENABLE, DRAM_ROWSTROBE_N;
  logic VRAM_ROWSTROBE_N, DRAM_COLSTROBE_N, VRAM_COLSTROBE_N;
  logic VRAM_WRITE_ENABLE_N, VRAM_OUTPUT_ENABLE_N, DRAM_OUTPUT_ENABLE_N;
  logic DRAM_WRITE_ENABLE_N, REFRESH_MODE_FLAG_N, REFRESH_ALL_N, HOLD;
  logic MEM_ADDR_NINTH_LINE, VRAM_BANK;
  logic [3:0] TABLE_OFFSET, exp_off;
  int miscompares, samples_checked, i;
  rcr_ram_control u_rcr_ram_control (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .CPU_ADDR(CPU_ADDR), .CPU_RD(CPU_RD), .CPU_WR(CPU_WR),
    .DRAM_SELECT(DRAM_SELECT), .VRAM_SELECT(VRAM_SELECT),
    .VRAM_4K_MODE(VRAM_4K_MODE), .FLAG_WR(FLAG_WR), .FLAG_DATA(FLAG_DATA),
    .HOLD_REQ_IN(HOLD_REQ_IN), .HOLDA(HOLDA), .TABLE_BASE(TABLE_BASE),
    .INTERLOAD_CODE_BIT0(INTERLOAD_CODE_BIT0),
    .INTERLOAD_CODE_BIT1(INTERLOAD_CODE_BIT1), .ROW_LOAD_WR(ROW_LOAD_WR),
    .ROW_LOAD_ADDR(ROW_LOAD_ADDR), .INTLD_DONE(INTLD_DONE),
    .ADDR_SELECT(ADDR_SELECT), .VRAM_COLSTROBE_ENABLE(VRAM_COLSTROBE_ENABLE),
    .DRAM_COLSTROBE_ENABLE(DRAM_COLSTROBE_ENABLE),
    .DRAM_ROWSTROBE_N(DRAM_ROWSTROBE_N), .VRAM_ROWSTROBE_N(VRAM_ROWSTROBE_N),
    .DRAM_COLSTROBE_N(DRAM_COLSTROBE_N), .VRAM_COLSTROBE_N(VRAM_COLSTROBE_N),
    .VRAM_WRITE_ENABLE_N(VRAM_WRITE_ENABLE_N),
    .VRAM_OUTPUT_ENABLE_N(VRAM_OUTPUT_ENABLE_N),
    .DRAM_OUTPUT_ENABLE_N(DRAM_OUTPUT_ENABLE_N),
    .DRAM_WRITE_ENABLE_N(DRAM_WRITE_ENABLE_N),
    .REFRESH_MODE_FLAG_N(REFRESH_MODE_FLAG_N), .REFRESH_ALL_N(REFRESH_ALL_N),
    .HOLD(HOLD), .MEM_ADDR_LINES(MEM_ADDR_LINES),
    .MEM_ADDR_NINTH_LINE(MEM_ADDR_NINTH_LINE), .VRAM_BANK(VRAM_BANK),
    .TABLE_OFFSET(TABLE_OFFSET));
  rcr_mem_model u_rcr_mem_model (.clk(SYS_CLK), .rst_n(RESETN),
    .dram_ras_n(DRAM_ROWSTROBE_N), .dram_cas_n(DRAM_COLSTROBE_N),
    .vram_ras_n(VRAM_ROWSTROBE_N), .vram_cas_n(VRAM_COLSTROBE_N),
    .dram_cbr(dram_cbr), .vram_cbr(vram_cbr), .ras_off(ras_off));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic cond(input int k);
    case (k)
      1: return DRAM_COLSTROBE_N === 1'b1;
      2: return ADDR_SELECT === SEL_L_ROW;
      3: return TABLE_OFFSET === exp_off;
      default: return VRAM_ROWSTROBE_N === 1'b1;
    endcase
  endfunction
  // Bounded wait; running out ends the run as a mismatch
  task automatic wait_for(input int k);
    for (int n = 0; n < 60 && !cond(k); n++) @(negedge SYS_CLK);
    if (!cond(k)) begin
      miscompares++;
      $display("BAD t=%0t wait %0d ran out", $time, k);
      report_and_stop();
    end
  endtask
  task automatic flag_wr(input logic v);
    @(posedge SYS_CLK);
    FLAG_WR <= 1'b1;
    FLAG_DATA <= v;
    @(posedge SYS_CLK);
    FLAG_WR <= 1'b0;
    repeat (2) @(negedge SYS_CLK);
  endtask
  task automatic cpu(input logic rd, input logic ds, input logic vs,
                     input logic [18:0] a);
    @(posedge SYS_CLK);
    CPU_ADDR <= a;
    CPU_RD <= rd;
    CPU_WR <= !rd;
    DRAM_SELECT <= ds;
    VRAM_SELECT <= vs;
    repeat (2) @(negedge SYS_CLK);
    chk({DRAM_ROWSTROBE_N, VRAM_ROWSTROBE_N}, {!ds, ds}, "ras");
    chk(ADDR_SELECT, SEL_P_ROW, "row sel");
    chk(MEM_ADDR_LINES, a[8:1], "row addr");
    if (ds) chk(MEM_ADDR_NINTH_LINE, a[17], "ninth row");
    @(negedge SYS_CLK);
    chk(ADDR_SELECT, SEL_P_COL, "col sel");
    chk(MEM_ADDR_LINES, a[16:9], "col addr");
    if (ds) chk(MEM_ADDR_NINTH_LINE, a[18], "ninth col");
    chk({DRAM_COLSTROBE_ENABLE, VRAM_COLSTROBE_ENABLE}, {ds, !ds},
        "en");
    chk({DRAM_COLSTROBE_N, VRAM_COLSTROBE_N}, {!ds, ds}, "cas");
    chk({DRAM_OUTPUT_ENABLE_N, DRAM_WRITE_ENABLE_N},
        ds ? {!rd, rd} : 2'b11, "dram oe we");
    chk({VRAM_OUTPUT_ENABLE_N, VRAM_WRITE_ENABLE_N},
        ds ? 2'b11 : {!rd, rd}, "vram oe we");
    if (!ds) chk(VRAM_BANK, VRAM_4K_MODE & a[17], "bank");
    @(posedge SYS_CLK);
    CPU_RD <= 1'b0;
    CPU_WR <= 1'b0;
    DRAM_SELECT <= 1'b0;
    VRAM_SELECT <= 1'b0;
    repeat (2) @(negedge SYS_CLK);
    chk({DRAM_ROWSTROBE_N, VRAM_ROWSTROBE_N, DRAM_COLSTROBE_N,
         VRAM_COLSTROBE_N}, 4'hF, "released");
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic other_rd(input logic rf);
    logic [7:0] d0, v0;
    d0 = dram_cbr;
    v0 = vram_cbr;
    @(posedge SYS_CLK);
    CPU_RD <= 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk({DRAM_COLSTROBE_N, VRAM_COLSTROBE_N}, {!rf, !rf}, "cbr cas");
    chk({DRAM_ROWSTROBE_N, VRAM_ROWSTROBE_N}, 2'b11, "cbr ras late");
    @(negedge SYS_CLK);
    chk(REFRESH_ALL_N, !rf, "refresh all");
    repeat (5) @(posedge SYS_CLK);
    CPU_RD <= 1'b0;
    repeat (6) @(negedge SYS_CLK);
    chk(dram_cbr, d0 + rf, "dram refresh");
    chk(vram_cbr, v0 + rf, "vram refresh");
  endtask
  task automatic table_cyc(input logic [1:0] code);
    logic [7:0] d0, v0, row;
    d0 = dram_cbr;
    v0 = vram_cbr;
    row = (code == 2'h1) ? {ROW_LOAD_ADDR[7:1], 1'b1}
                         : {ROW_LOAD_ADDR[7:2], code};
    @(posedge SYS_CLK);
    INTERLOAD_CODE_BIT0 <= code[0];
    INTERLOAD_CODE_BIT1 <= code[1];
    HOLDA <= 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk(DRAM_ROWSTROBE_N, 1'b0, "table ras");
    chk(ADDR_SELECT, SEL_T_ROW, "table row sel");
    chk(MEM_ADDR_LINES, {TABLE_BASE[7:4], exp_off}, "entry row");
    @(negedge SYS_CLK);
    chk(ADDR_SELECT, SEL_T_COL, "table col sel");
    chk(MEM_ADDR_LINES, TABLE_BASE[15:8], "entry col");
    chk({DRAM_COLSTROBE_N, DRAM_OUTPUT_ENABLE_N}, 2'b00, "entry rd");
    repeat (8) @(negedge SYS_CLK);
    chk(DRAM_ROWSTROBE_N, 1'b1, "ras off");
    chk({DRAM_COLSTROBE_N, DRAM_OUTPUT_ENABLE_N}, 2'b00,
        "data held");
    if (code == 2'h0) begin
      wait_for(1);
    end else begin
      wait_for(2);
      chk(MEM_ADDR_LINES, row, "load row");
      chk(VRAM_OUTPUT_ENABLE_N, 1'b0, "load oe");
      repeat (2) @(negedge SYS_CLK);
      chk(VRAM_ROWSTROBE_N, 1'b0, "load ras");
      @(posedge SYS_CLK);
      INTLD_DONE <= 1'b1;
      @(posedge SYS_CLK);
      INTLD_DONE <= 1'b0;
      wait_for(4);
    end
    @(posedge SYS_CLK);
    HOLDA <= 1'b0;
    // Ten cycles is exactly the off time, so strictly more is needed
    chk(ras_off > 8'd10, 1'b1, "ras off long");
    chk(dram_cbr, d0 + 8'h01, "dram hidden");
    chk(vram_cbr, v0 + {7'h00, code == 2'h0}, "vram cbr");
    exp_off = exp_off + 4'h1;
    wait_for(3);
    repeat (4) @(posedge SYS_CLK);
  endtask
  initial begin
    {RESETN, CPU_RD, CPU_WR, DRAM_SELECT, VRAM_SELECT, VRAM_4K_MODE} = 6'h00;
    {FLAG_WR, FLAG_DATA, HOLD_REQ_IN, HOLDA, ROW_LOAD_WR, INTLD_DONE} = 6'h00;
    {INTERLOAD_CODE_BIT0, INTERLOAD_CODE_BIT1} = 2'h0;
    CPU_ADDR = 19'h00000;
    TABLE_BASE = 16'h9D60;
    ROW_LOAD_ADDR = 8'hC4;
    exp_off = 4'h0;
    repeat (20) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    @(negedge SYS_CLK);
    chk({DRAM_ROWSTROBE_N, VRAM_ROWSTROBE_N, DRAM_COLSTROBE_N,
         VRAM_COLSTROBE_N, VRAM_WRITE_ENABLE_N, VRAM_OUTPUT_ENABLE_N,
         DRAM_OUTPUT_ENABLE_N, DRAM_WRITE_ENABLE_N}, 8'hFF, "rst n");
    chk({REFRESH_MODE_FLAG_N, REFRESH_ALL_N, HOLD, TABLE_OFFSET}, 7'h60,
        "rst misc");
    $display("test reset done");
    cpu(1'b1, 1'b1, 1'b0, 19'h5A5B6);
    cpu(1'b0, 1'b1, 1'b0, 19'h23C7E);
    cpu(1'b1, 1'b1, 1'b1, 19'h62D5A);
    cpu(1'b0, 1'b0, 1'b1, 19'h2F0F2);
    VRAM_4K_MODE <= 1'b1;
    cpu(1'b1, 1'b0, 1'b1, 19'h21234);
    cpu(1'b0, 1'b0, 1'b1, 19'h01234);
    $display("test processor cycles done");
    flag_wr(1'b1);
    chk(REFRESH_MODE_FLAG_N, 1'b0, "flag set");
    @(posedge SYS_CLK);
    HOLD_REQ_IN <= 1'b1;
    repeat (4) @(negedge SYS_CLK);
    chk(HOLD, 1'b0, "hold blocked");
    other_rd(1'b1);
    cpu(1'b1, 1'b1, 1'b0, 19'h1ACE4);
    chk(REFRESH_MODE_FLAG_N, 1'b0, "flag kept");
    flag_wr(1'b0);
    chk(HOLD, 1'b1, "hold passes");
    @(posedge SYS_CLK);
    HOLD_REQ_IN <= 1'b0;
    other_rd(1'b0);
    $display("test refresh flag done");
    @(posedge SYS_CLK);
    ROW_LOAD_WR <= 1'b1;
    @(posedge SYS_CLK);
    ROW_LOAD_WR <= 1'b0;
    // Five plain entries among seventeen, wrapping the offset once
    for (i = 0; i < 17; i++) table_cyc(i[1:0]);
    $display("test table cycles done");
    report_and_stop();
  end
endmodule
